// file: design/td_cfg.svh
// Offsets, field positions, reset values and timing for the transfer descriptor block
`ifndef TD_CFG_SVH
`define TD_CFG_SVH
// ****************************************
// Register offsets
// ****************************************
`define TD_OFS_DESC0 4'h0
`define TD_OFS_DESC1 4'h4
`define TD_OFS_STAT 4'h8
`define TD_OFS_MASK 4'hC
`define TD_ADR_W 4
// ****************************************
// Descriptor word 0 fields
// ****************************************
`define TD_MAXP_LSB 0
`define TD_TOGGLE_BIT 10
`define TD_ENABLE_BIT 11
`define TD_RESULT_LSB 12
`define TD_ENDP_LSB 16
`define TD_LAST_BIT 20
`define TD_SPEED_BIT 21
`define TD_BUSY_BIT 22
// ****************************************
// Descriptor word 1 fields
// ****************************************
`define TD_COUNT_LSB 0
`define TD_DIR_LSB 10
`define TD_RATE_BIT 12
`define TD_FORMAT_BIT 13
`define TD_ADDR_LSB 14
`define TD_MOVED_LSB 21
// ****************************************
// Interrupt bits
// ****************************************
`define TD_IRQ_DONE 0
`define TD_IRQ_ERROR 1
`define TD_IRQ_LAST 2
// ****************************************
// Codes and timing
// ****************************************
`define TD_RC_CLEAN 4'h0
`define TD_RC_NO_REPLY 4'h5
`define TD_RC_FETCH_SLOW 4'hD
`define TD_DIR_SETUP 2'h0
`define TD_DIR_OUT 2'h1
`define TD_DIR_IN 2'h2
`define TD_DIR_RSVD 2'h3
`define TD_RATE_RESET 1'h0
`define TD_MS_NS 1000000
`define TD_CLK_NS 50
`endif

// file: design/td_pkg.sv
// Types shared by the transfer descriptor block
package td_pkg;
    typedef logic [9:0] td_len_type;
    typedef logic [6:0] td_addr_type;
    typedef logic [3:0] td_code_type;
    typedef enum logic [1:0] {TD_IDLE, TD_WAIT} td_state_type;
endpackage

// file: design/td_descriptor_ctrl.sv
// Transfer descriptor controller with Wishbone register slave
// Summary of operation
// - Clean finish writes result code 0000
// - No reply reports result code 0101
// - Slow OUT payload fetch reports 1101
// - Hardware clears enable when descriptor finishes
// - Toggle bit tracks expected data PID
// - Ten-bit maximum packet bytes field
// - Last flag marks final list descriptor
// - Byte count above packet size: bulk/control
// - Rate limit bit zero after reset
// - Rate limited interrupt: one transaction per ms
// - Format bit selects isochronous handling
// - Seven-bit target device address per transaction
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "td_cfg.svh"
module td_descriptor_ctrl #(
    parameter int MS_CYCLES = `TD_MS_NS / `TD_CLK_NS
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`TD_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic txn_start_o,
    output td_pkg::td_addr_type txn_addr_o,
    output logic [3:0] txn_endp_o,
    output logic [1:0] txn_dir_o,
    output logic txn_low_speed_o,
    output logic txn_iso_o,
    output logic txn_toggle_o,
    output td_pkg::td_len_type txn_len_o,
    input wire logic txn_done_i,
    input wire logic txn_no_reply_i,
    input wire logic txn_fetch_slow_i,
    input wire td_pkg::td_len_type txn_bytes_i,
    output logic irq_o
);
    import td_pkg::*;

    // ****************************************
    // Descriptor and control state
    // ****************************************
    td_state_type state_r;
    td_len_type max_packet_bytes_r, transfer_byte_count_r, moved_r;
    td_addr_type target_device_address_r;
    td_code_type result_code_r;
    logic [3:0] endpoint_index_r;
    logic [1:0] direction_code_r;
    logic toggle_r, enable_r, last_r, speed_r, rate_limit_bit_r, format_r;
    logic [2:0] irq_stat_r, irq_mask_r;
    logic sent_this_ms_r, ms_tick;
    logic [31:0] ms_cnt_r;

    // ****************************************
    // Bus decode
    // ****************************************
    logic bus_req, bus_wr, wr_desc0, wr_desc1, wr_stat, wr_mask;
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr = bus_req & wb_we_i;
    assign wr_desc0 = bus_wr & (wb_adr_i == `TD_OFS_DESC0) & (state_r == TD_IDLE);
    assign wr_desc1 = bus_wr & (wb_adr_i == `TD_OFS_DESC1) & (state_r == TD_IDLE);
    assign wr_stat = bus_wr & (wb_adr_i == `TD_OFS_STAT) & wb_sel_i[0];
    assign wr_mask = bus_wr & (wb_adr_i == `TD_OFS_MASK) & wb_sel_i[0];

    // ****************************************
    // Transaction decisions
    // ****************************************
    logic rate_gated, gate_ok, issue, ok_done, err_slow, err_none, finish;
    logic [10:0] remain, moved_sum;
    td_len_type pkt_len;
    td_code_type code_nxt;
    assign rate_gated = rate_limit_bit_r & ~format_r;
    assign gate_ok = ~rate_gated | ~sent_this_ms_r;
    assign issue = (state_r == TD_IDLE) & enable_r & (direction_code_r != `TD_DIR_RSVD) & gate_ok
                   & ~wr_desc0 & ~wr_desc1;
    assign remain = {1'b0, transfer_byte_count_r} - {1'b0, moved_r};
    assign pkt_len = (remain > {1'b0, max_packet_bytes_r}) ? max_packet_bytes_r : remain[9:0];
    assign moved_sum = {1'b0, moved_r} + {1'b0, txn_bytes_i};
    assign ok_done = (state_r == TD_WAIT) & txn_done_i;
    assign err_slow = txn_fetch_slow_i & (direction_code_r == `TD_DIR_OUT);
    assign err_none = txn_no_reply_i;
    assign finish = ok_done & (err_slow | err_none | format_r | (txn_bytes_i < max_packet_bytes_r)
                    | (moved_sum >= {1'b0, transfer_byte_count_r}));

    assign code_nxt = err_slow ? `TD_RC_FETCH_SLOW : (err_none ? `TD_RC_NO_REPLY : `TD_RC_CLEAN);

    // ****************************************
    // State machine
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= TD_IDLE;
        end
        else
        begin
            unique case (state_r)
                TD_IDLE:
                begin
                    if (issue)
                    begin
                        state_r <= TD_WAIT;
                    end
                end
                TD_WAIT:
                begin
                    if (txn_done_i)
                    begin
                        state_r <= TD_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Descriptor fields
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            max_packet_bytes_r <= 10'h000;
            toggle_r <= 1'b0;
            enable_r <= 1'b0;
            result_code_r <= `TD_RC_CLEAN;
            endpoint_index_r <= 4'h0;
            last_r <= 1'b0;
            speed_r <= 1'b0;
            transfer_byte_count_r <= 10'h000;
            direction_code_r <= `TD_DIR_SETUP;
            rate_limit_bit_r <= `TD_RATE_RESET;
            format_r <= 1'b0;
            target_device_address_r <= 7'h00;
            moved_r <= 10'h000;
        end
        else
        begin
            if (wr_desc0)
            begin
                max_packet_bytes_r <= wb_dat_i[`TD_MAXP_LSB +: 10];
                toggle_r <= wb_dat_i[`TD_TOGGLE_BIT];
                enable_r <= wb_dat_i[`TD_ENABLE_BIT];
                result_code_r <= wb_dat_i[`TD_RESULT_LSB +: 4];
                endpoint_index_r <= wb_dat_i[`TD_ENDP_LSB +: 4];
                last_r <= wb_dat_i[`TD_LAST_BIT];
                speed_r <= wb_dat_i[`TD_SPEED_BIT];
                moved_r <= 10'h000;
            end
            if (wr_desc1)
            begin
                transfer_byte_count_r <= wb_dat_i[`TD_COUNT_LSB +: 10];
                direction_code_r <= wb_dat_i[`TD_DIR_LSB +: 2];
                rate_limit_bit_r <= wb_dat_i[`TD_RATE_BIT];
                format_r <= wb_dat_i[`TD_FORMAT_BIT];
                target_device_address_r <= wb_dat_i[`TD_ADDR_LSB +: 7];
            end
            if (ok_done)
            begin
                moved_r <= moved_sum[9:0];
                if (~err_slow & ~err_none & ~format_r)
                begin
                    toggle_r <= ~toggle_r;
                end
            end
            if (finish)
            begin
                enable_r <= 1'b0;
                result_code_r <= code_nxt;
            end
        end
    end

    // ****************************************
    // Millisecond pacing
    // ****************************************
    assign ms_tick = (ms_cnt_r == 32'(MS_CYCLES - 1));
    always_ff @(posedge clk_i)
    begin
        ms_cnt_r <= (rst_i | ms_tick) ? 32'h0000_0000 : ms_cnt_r + 32'h0000_0001;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sent_this_ms_r <= 1'b0;
        end
        else if (ms_tick)
        begin
            sent_this_ms_r <= 1'b0;
        end
        else if (issue & rate_gated)
        begin
            sent_this_ms_r <= 1'b1;
        end
    end

    // ****************************************
    // Transaction request outputs
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            txn_start_o <= 1'b0;
            txn_addr_o <= 7'h00;
            txn_endp_o <= 4'h0;
            txn_dir_o <= `TD_DIR_SETUP;
            txn_low_speed_o <= 1'b0;
            txn_iso_o <= 1'b0;
            txn_toggle_o <= 1'b0;
            txn_len_o <= 10'h000;
        end
        else
        begin
            txn_start_o <= issue;
            if (issue)
            begin
                txn_addr_o <= target_device_address_r;
                txn_endp_o <= endpoint_index_r;
                txn_dir_o <= direction_code_r;
                txn_low_speed_o <= speed_r;
                txn_iso_o <= format_r;
                txn_toggle_o <= toggle_r;
                txn_len_o <= pkt_len;
            end
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    logic [2:0] irq_set;
    assign irq_set = {finish & last_r, finish & (err_slow | err_none), finish};
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_stat_r <= 3'h0;
            irq_mask_r <= 3'h0;
            irq_o <= 1'b0;
        end
        else
        begin
            irq_stat_r <= (irq_stat_r & ~(wr_stat ? wb_dat_i[2:0] : 3'h0)) | irq_set;
            if (wr_mask)
            begin
                irq_mask_r <= wb_dat_i[2:0];
            end
            irq_o <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ****************************************
    // Wishbone answer
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h0000_0000;
            if (bus_req & ~wb_we_i)
            begin
                unique case (wb_adr_i)
                    `TD_OFS_DESC0: wb_dat_o <= {9'h000, (state_r == TD_WAIT), speed_r, last_r, endpoint_index_r,
                                              result_code_r, enable_r, toggle_r, max_packet_bytes_r};
                    `TD_OFS_DESC1: wb_dat_o <= {1'b0, moved_r, target_device_address_r, format_r,
                                              rate_limit_bit_r, direction_code_r, transfer_byte_count_r};
                    `TD_OFS_STAT: wb_dat_o <= {29'h0000_0000, irq_stat_r};
                    `TD_OFS_MASK: wb_dat_o <= {29'h0000_0000, irq_mask_r};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_clean_code: assert property (@(posedge clk_i) disable iff (rst_i)
        finish & ~err_slow & ~err_none |=> result_code_r == 4'h0)
        else $error("clean finish did not give code 0");
    a_no_reply_code: assert property (@(posedge clk_i) disable iff (rst_i)
        finish & err_none & ~err_slow |=> result_code_r == 4'h5)
        else $error("no reply did not give code 5");
    a_fetch_slow_code: assert property (@(posedge clk_i) disable iff (rst_i)
        ok_done & txn_fetch_slow_i & (direction_code_r == 2'h1) |=> result_code_r == 4'hD && !enable_r)
        else $error("slow fetch did not give code D");
    a_enable_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        finish |=> !enable_r ##1 !txn_start_o)
        else $error("enable not cleared at finish");
    a_toggle_flip: assert property (@(posedge clk_i) disable iff (rst_i)
        ok_done & ~err_slow & ~err_none & ~format_r |=> toggle_r != $past(toggle_r))
        else $error("toggle not updated after good packet");
    a_len_bound: assert property (@(posedge clk_i) disable iff (rst_i)
        txn_start_o |-> txn_len_o <= max_packet_bytes_r && txn_len_o <= transfer_byte_count_r)
        else $error("packet length above limit");
    a_last_irq: assert property (@(posedge clk_i) disable iff (rst_i)
        finish & last_r |=> irq_stat_r[2])
        else $error("last descriptor not flagged");
    a_rate_reset: assert property (@(posedge clk_i)
        rst_i |=> !rate_limit_bit_r)
        else $error("rate limit bit not zero after reset");
    a_rate_once: assert property (@(posedge clk_i) disable iff (rst_i)
        issue & rate_gated & ~ms_tick |=> sent_this_ms_r)
        else $error("rate limited transaction not marked in its window");
    a_iso_single: assert property (@(posedge clk_i) disable iff (rst_i)
        ok_done & format_r |=> !enable_r && toggle_r == $past(toggle_r))
        else $error("isochronous descriptor ran more than once");
    a_addr_out: assert property (@(posedge clk_i) disable iff (rst_i)
        issue |=> txn_start_o && txn_addr_o == $past(target_device_address_r))
        else $error("transaction address wrong");
    a_reserved_dir: assert property (@(posedge clk_i) disable iff (rst_i)
        (direction_code_r == 2'h3) & (state_r == TD_IDLE) |=> !txn_start_o)
        else $error("reserved direction started a transaction");
    a_speed_endp: assert property (@(posedge clk_i) disable iff (rst_i)
        issue |=> txn_low_speed_o == $past(speed_r) && txn_endp_o == $past(endpoint_index_r))
        else $error("speed or endpoint wrong");
endmodule

// file: test/td_usb_engine_model.sv
// USB engine model answering transaction starts from the descriptor block
`timescale 1ns/1ns
module td_usb_engine_model (
    input wire logic clk_i,
    input wire logic start_i,
    input wire td_pkg::td_len_type len_i,
    input wire logic [1:0] mode_i,
    output logic done_o,
    output logic no_reply_o,
    output logic fetch_slow_o,
    output td_pkg::td_len_type bytes_o
);
    import td_pkg::*;
    // ****************************************
    // Engine answer, prompt or slow
    // ****************************************
    int wait_n;
    logic busy;
    logic fire;
    initial
    begin
        done_o = 1'b0;
        no_reply_o = 1'b1;
        fetch_slow_o = 1'b1;
        bytes_o = 10'h3FF;
        busy = 1'b0;
        wait_n = 0;
    end
    always @(posedge clk_i)
    begin
        fire = busy && wait_n <= 1 && start_i !== 1'b1;
        if (start_i === 1'b1)
        begin
            busy <= 1'b1;
            wait_n <= 1 + int'($urandom % 12);
        end
        else if (busy && wait_n > 1)
            wait_n <= wait_n - 1;
        else if (busy)
            busy <= 1'b0;
        if (fire)
        begin
            done_o <= 1'b1;
            no_reply_o <= (mode_i == 2'h1);
            fetch_slow_o <= (mode_i == 2'h2);
            bytes_o <= (mode_i == 2'h0) ? len_i : 10'h000;
        end
        else
        begin
            done_o <= 1'b0;
            no_reply_o <= ~no_reply_o;
            fetch_slow_o <= ~fetch_slow_o;
            bytes_o <= ~bytes_o;
        end
    end
endmodule

// file: test/tb.sv
// Self-checking testbench for the transfer descriptor controller
`timescale 1ns/1ns
module tb;
    import td_pkg::*;
    localparam int MS = 50;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, txn_start_o, txn_low_speed_o, txn_iso_o, txn_toggle_o, irq_o;
    logic txn_done_i, txn_no_reply_i, txn_fetch_slow_i;
    td_addr_type txn_addr_o, e_addr;
    logic [3:0] txn_endp_o, e_endp;
    logic [1:0] txn_dir_o, e_dir, mode = 2'h0;
    td_len_type txn_len_o, txn_bytes_i;
    logic e_ls, e_iso, e_tog, rate_on = 0, msk = 1;
    int n_errors = 0, num_checks = 0, cycles = 0, n_starts = 0, rem, maxp, t1, t2, i, t, m;
    td_descriptor_ctrl #(.MS_CYCLES(MS)) td_descriptor_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txn_start_o(txn_start_o),
        .txn_addr_o(txn_addr_o), .txn_endp_o(txn_endp_o), .txn_dir_o(txn_dir_o),
        .txn_low_speed_o(txn_low_speed_o), .txn_iso_o(txn_iso_o), .txn_toggle_o(txn_toggle_o),
        .txn_len_o(txn_len_o), .txn_done_i(txn_done_i), .txn_no_reply_i(txn_no_reply_i),
        .txn_fetch_slow_i(txn_fetch_slow_i), .txn_bytes_i(txn_bytes_i), .irq_o(irq_o));
    td_usb_engine_model td_usb_engine_model_inst (.clk_i(clk_i), .start_i(txn_start_o), .len_i(txn_len_o),
        .mode_i(mode), .done_o(txn_done_i), .no_reply_o(txn_no_reply_i), .fetch_slow_o(txn_fetch_slow_i),
        .bytes_o(txn_bytes_i));
    // ****************************************
    // Clock, timeout and shared tasks
    // ****************************************
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            n_errors++;
            stop_test();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
            @(posedge clk_i);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // ****************************************
    // Transaction monitor
    // ****************************************
    always @(posedge clk_i)
        if (txn_start_o === 1'b1)
        begin
            chk(txn_addr_o, e_addr);
            chk({txn_endp_o, txn_low_speed_o}, {e_endp, e_ls});
            chk(txn_dir_o, e_dir);
            chk(txn_iso_o, e_iso);
            chk(txn_toggle_o, e_tog);
            chk(txn_len_o, rem < maxp ? rem : maxp);
            if (rate_on && n_starts >= 2)
                chk(cycles - t2 > MS, 1);
            t2 = t1;
            t1 = cycles;
            n_starts++;
            if (!e_iso && mode == 2'h0)
                e_tog = ~e_tog;
            rem = rem - int'(txn_len_o);
        end
    // ****************************************
    // One descriptor from setup to completion
    // ****************************************
    task run(input logic [1:0] dir, input logic fmt, input logic rt, input logic [1:0] md, input int tot,
        input int mx, input int en, input logic [3:0] code, input logic last);
        int k;
        e_addr = 7'($urandom);
        e_endp = 4'($urandom);
        e_ls = 1'($urandom);
        e_tog = 1'($urandom);
        e_dir = dir;
        e_iso = fmt;
        rate_on = rt;
        mode = md;
        rem = tot;
        maxp = mx;
        n_starts = 0;
        wb(1'b1, 4'h4, {11'h000, e_addr, fmt, rt, dir, tot[9:0]});
        wb(1'b1, 4'h0, {10'h000, e_ls, last, e_endp, 4'h0, 1'b1, e_tog, mx[9:0]});
        rd = 32'hFFFFFFFF;
        for (k = 0; k < 2000 && rd[11] !== 1'b0; k++)
            wb(1'b0, 4'h0, 32'h0);
        chk(rd[15:12], code);
        chk(rd[11], 1'b0);
        chk(rd[10], e_tog);
        chk(n_starts, en);
        wb(1'b0, 4'h4, 32'h0);
        chk(rd[30:21], md != 2'h0 ? 0 : ((fmt && tot > mx) ? mx : tot));
        wb(1'b0, 4'h8, 32'h0);
        chk(rd[2:0], {last, md != 2'h0, 1'b1});
        chk(irq_o, msk);
        wb(1'b1, 4'h8, 32'h7);
        repeat (2) @(posedge clk_i);
        chk(irq_o, 1'b0);
        $display("test done: dir %0d format %0d code %h", dir, fmt, code);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        void'($urandom(32'h1E721DA4));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, 4'h4, 32'h0);
        chk(rd[12], 1'b0);
        wb(1'b1, 4'h6, 32'hFFFFFFFF);
        wb(1'b0, 4'h6, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, 4'hC, 32'h7);
        wb(1'b0, 4'hC, 32'h0);
        chk(rd[2:0], 3'h7);
        $display("test done: reset and map");
        for (i = 0; i < 4; i++)
        begin
            t = (i == 0) ? 128 : 1 + int'($urandom % 300);
            m = (i == 0) ? 64 : 1 + int'($urandom % 64);
            run(i[1:0] % 3, 1'b0, 1'b0, 2'h0, t, m, (t + m - 1) / m, 4'h0, i[0]);
        end
        run(2'h2, 1'b0, 1'b0, 2'h0, 600, 1023, 1, 4'h0, 1'b0);
        run(2'h2, 1'b1, 1'b0, 2'h0, 16, 32, 1, 4'h0, 1'b1);
        run(2'h2, 1'b0, 1'b0, 2'h1, 100, 10, 1, 4'h5, 1'b0);
        run(2'h1, 1'b0, 1'b0, 2'h2, 100, 10, 1, 4'hD, 1'b0);
        run(2'h1, 1'b0, 1'b1, 2'h0, 40, 10, 4, 4'h0, 1'b0);
        n_starts = 0;
        wb(1'b1, 4'h4, 32'h00000C08);
        wb(1'b1, 4'h0, 32'h00000808);
        repeat (20) @(posedge clk_i);
        chk(n_starts, 0);
        wb(1'b0, 4'h0, 32'h0);
        chk(rd[11], 1'b1);
        wb(1'b1, 4'h0, 32'h00000008);
        wb(1'b1, 4'h4, 32'h00000408);
        repeat (20) @(posedge clk_i);
        chk(n_starts, 0);
        $display("test done: reserved direction and disabled descriptor");
        wb(1'b1, 4'hC, 32'h0);
        msk = 1'b0;
        run(2'h0, 1'b0, 1'b0, 2'h0, 8, 8, 1, 4'h0, 1'b0);
        stop_test();
    end
endmodule
